//--- common/imrst_pkg.sv
// Constants, register map and types of the two-wire partner controller.
// Assumes a 25 MHz pclk; every user of these names writes imrst_pkg::name.
package imrst_pkg;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int         CLK_PERIOD_NS = 40;
   localparam int         QUARTER_NS    = 2500;
   localparam int         QUARTER_CYC   = (QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [7:0] QUARTER_TOP   = 8'(QUARTER_CYC - 1);

   // ----------------------------------------------------------------
   // Register map and fields
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_ADDR = 8'h04;
   localparam logic [7:0] OFS_TXD  = 8'h08;
   localparam logic [7:0] OFS_RXD  = 8'h0C;
   localparam logic [7:0] OFS_STAT = 8'h10;
   localparam logic [7:0] OFS_LEN  = 8'h14;
   localparam int CTRL_SLV_EN = 0;
   localparam int CTRL_GO     = 1;
   localparam int CTRL_MTEN   = 2;
   localparam int CTRL_OTEN   = 3;
   localparam int ADDR_TGT    = 16;
   localparam int STAT_NACK   = 3;
   localparam int STAT_STOP   = 5;
   localparam int STAT_CNT    = 8;

   // ----------------------------------------------------------------
   // Bus encodings
   // ----------------------------------------------------------------
   localparam logic [4:0] TEN_PREFIX = 5'h1E;
   localparam logic [3:0] ACK_BIT    = 4'h8;
   localparam logic [3:0] LAST_DBIT  = 4'h7;
   localparam logic [2:0] S_LAST     = 3'h7;
   localparam logic [1:0] PH0 = 2'h0;
   localparam logic [1:0] PH1 = 2'h1;
   localparam logic [1:0] PH2 = 2'h2;
   localparam logic [1:0] PH3 = 2'h3;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {M_IDLE, M_START, M_BIT, M_STOP} imrst_mstate_type;
   typedef enum logic [2:0] {ST_FIRST, ST_SECOND, ST_FIRST_RD, ST_DATA} imrst_step_type;
   typedef enum logic [2:0] {S_IDLE, S_ADDR, S_AACK, S_TWAIT, S_TX, S_TACK, S_SKIP} imrst_sstate_type;
   typedef struct packed {
      logic scl;
      logic sda;
   } imrst_line_type;

endpackage : imrst_pkg

//--- rtl/imrst_partner.sv
// Two-wire bus partner: reads from the channel as a master and feeds it as a slave transmitter.
// Assumes open-drain bus lines resolved by the surroundings and an APB master on pclk.
//
// What this block does
// - A nack request set before the byte completes turns the ack into nack.
// - A 7-bit read address byte carries the address above a read bit of 1.
// - A 10-bit address goes as a high-bits-plus-direction byte then eight low bits.
// - A 10-bit write sends start, first byte with write, then the full second byte.
// - A 10-bit read then repeats start and resends the first byte with read set.
// - Event flags clear by writing 1 to them; here the addressed flag (bit 4) ignores the write and clears only at a stop.
// - On a nack during a read, set the flag and request a stop.
// - A single-byte read has nack requested before the start.
// - In longer reads nack goes on the last byte, then a stop follows.
// - The slave transmits only when the received direction bit is 1.
//
// Local design decisions: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module imrst_partner (
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Serial clock pin
   input  wire logic        serial_clock_pin_i,
   output logic             serial_clock_pin_o,
   output logic             serial_clock_pin_oe_n,
   // Serial data pin
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oe_n
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   imrst_pkg::imrst_line_type   line_m_q, line_s_q, line_p_q;
   imrst_pkg::imrst_mstate_type m_st_q, m_st_d;
   imrst_pkg::imrst_step_type   m_step_q, m_step_d;
   imrst_pkg::imrst_sstate_type s_st_q, s_st_d;
   logic [1:0]  m_ph_q, m_ph_d;
   logic [3:0]  m_bit_q, m_bit_d;
   logic [7:0]  m_byte_q, m_byte_d, qcnt_q, qcnt_d, len_q, len_d, cnt_q, cnt_d;
   logic        m_rd_q, m_rd_d, m_scl_low_q, m_scl_low_d, m_sda_low_q, m_sda_low_d, m_ack_q, m_ack_d;
   logic [2:0]  s_cnt_q, s_cnt_d;
   logic [7:0]  s_shift_q, s_shift_d, txd_q, txd_d, rxd_q, rxd_d;
   logic        s_scl_low_q, s_scl_low_d, s_sda_low_q, s_sda_low_d, s_ten_ok_q, s_ten_ok_d;
   logic        s_second_q, s_second_d, s_rd_q, s_rd_d, s_ack_q, s_ack_d, s_addr_q, s_addr_d;
   logic        slv_en_q, slv_en_d, mten_q, mten_d, oten_q, oten_d;
   logic [9:0]  own_q, own_d, tgt_q, tgt_d;
   logic        tx_full_q, tx_full_d, rx_full_q, rx_full_d, nack_q, nack_d, stop_q, stop_d;
   logic [31:0] prdata_q, prdata_d, rdval;
   logic        pready_q, pready_d, pslverr_q, pslverr_d, scl_oe_n_q, scl_oe_n_d, sda_oe_n_q, sda_oe_n_d;
   logic        tick, acc, hit, rise, fall, start_det, stop_det, adv, match;
   logic [7:0]  b;

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   // Two flops per pin; a third copy gives the previous synchronised level for edge finding.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         line_m_q <= '1;
         line_s_q <= '1;
         line_p_q <= '1;
      end else begin
         line_m_q <= '{scl: serial_clock_pin_i, sda: sda_i};
         line_s_q <= line_m_q;
         line_p_q <= line_s_q;
      end
   end

   // Bus events and the quarter-bit tick.
   assign rise      = line_s_q.scl & ~line_p_q.scl;
   assign fall      = ~line_s_q.scl & line_p_q.scl;
   assign start_det = line_s_q.scl & line_p_q.scl & line_p_q.sda & ~line_s_q.sda;
   assign stop_det  = line_s_q.scl & line_p_q.scl & ~line_p_q.sda & line_s_q.sda;
   assign tick      = (qcnt_q == '0);
   assign acc       = psel & penable & pready_q;
   assign b         = {s_shift_q[6:0], line_s_q.sda};

   // ----------------------------------------------------------------
   // Register read mux
   // ----------------------------------------------------------------
   always_comb begin
      rdval = '0;
      hit   = 1'b1;
      case (paddr)
         imrst_pkg::OFS_CTRL: rdval = {28'h0000000, oten_q, mten_q, 1'b0, slv_en_q};
         imrst_pkg::OFS_ADDR: rdval = {6'h00, tgt_q, 6'h00, own_q};
         imrst_pkg::OFS_TXD:  rdval = {24'h000000, txd_q};
         imrst_pkg::OFS_RXD:  rdval = {24'h000000, rxd_q};
         imrst_pkg::OFS_STAT: rdval = {16'h0000, cnt_q, 2'h0, stop_q, s_addr_q, nack_q, rx_full_q,
                                       ~tx_full_q, (m_st_q != imrst_pkg::M_IDLE)};
         imrst_pkg::OFS_LEN:  rdval = {24'h000000, len_q};
         default:             hit   = 1'b0;
      endcase
   end

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   // Registers, master sequencer and slave transmitter; hardware sets come after software clears.
   always_comb begin
      m_st_d = m_st_q;  m_step_d = m_step_q;  m_ph_d = m_ph_q;  m_bit_d = m_bit_q;
      m_byte_d = m_byte_q;  m_rd_d = m_rd_q;  m_scl_low_d = m_scl_low_q;  m_sda_low_d = m_sda_low_q;
      m_ack_d = m_ack_q;  s_st_d = s_st_q;  s_cnt_d = s_cnt_q;  s_shift_d = s_shift_q;
      s_scl_low_d = s_scl_low_q;  s_sda_low_d = s_sda_low_q;  s_ten_ok_d = s_ten_ok_q;
      s_second_d = s_second_q;  s_rd_d = s_rd_q;  s_ack_d = s_ack_q;  s_addr_d = s_addr_q;
      slv_en_d = slv_en_q;  mten_d = mten_q;  oten_d = oten_q;  own_d = own_q;  tgt_d = tgt_q;
      txd_d = txd_q;  rxd_d = rxd_q;  tx_full_d = tx_full_q;  rx_full_d = rx_full_q;
      len_d = len_q;  cnt_d = cnt_q;  nack_d = nack_q;  stop_d = stop_q;  match = 1'b0;
      qcnt_d = tick ? imrst_pkg::QUARTER_TOP : qcnt_q - 8'h01;
      pready_d  = psel & penable & ~pready_q;
      pslverr_d = psel & penable & ~pready_q & ~hit;
      prdata_d  = (psel & penable & ~pready_q) ? rdval : prdata_q;
      // Software side of the register file.
      if (acc && pwrite) begin
         case (paddr)
            imrst_pkg::OFS_CTRL: begin
               slv_en_d = pwdata[imrst_pkg::CTRL_SLV_EN];
               mten_d   = pwdata[imrst_pkg::CTRL_MTEN];
               oten_d   = pwdata[imrst_pkg::CTRL_OTEN];
               if (pwdata[imrst_pkg::CTRL_GO] && m_st_q == imrst_pkg::M_IDLE) begin
                  m_st_d = imrst_pkg::M_START;
                  m_ph_d = imrst_pkg::PH0;
                  m_step_d = imrst_pkg::ST_FIRST;
                  m_rd_d = 1'b0;
                  cnt_d = '0;
                  m_byte_d = pwdata[imrst_pkg::CTRL_MTEN]
                           ? {imrst_pkg::TEN_PREFIX, tgt_q[9:8], 1'b0}
                           : {tgt_q[6:0], 1'b1};
               end
            end
            imrst_pkg::OFS_ADDR: begin
               own_d = pwdata[9:0];
               tgt_d = pwdata[imrst_pkg::ADDR_TGT +: 10];
            end
            imrst_pkg::OFS_TXD: begin
               txd_d = pwdata[7:0];
               tx_full_d = 1'b1;
            end
            imrst_pkg::OFS_STAT: begin
               if (pwdata[imrst_pkg::STAT_NACK]) nack_d = 1'b0;
               if (pwdata[imrst_pkg::STAT_STOP]) stop_d = 1'b0;
            end
            imrst_pkg::OFS_LEN: len_d = pwdata[7:0];
            default: ;
         endcase
      end
      if (acc && !pwrite && paddr == imrst_pkg::OFS_RXD) rx_full_d = 1'b0;
      // Master sequencer: four quarter phases per bit; the high phase waits for a released clock.
      adv = tick & ((m_ph_q != ((m_st_q == imrst_pkg::M_BIT) ? imrst_pkg::PH1 : imrst_pkg::PH2))
                    | line_s_q.scl);
      case (m_st_q)
         imrst_pkg::M_START: if (adv) begin
            m_ph_d = m_ph_q + 2'h1;
            case (m_ph_q)
               imrst_pkg::PH0: m_sda_low_d = 1'b0;
               imrst_pkg::PH1: m_scl_low_d = 1'b0;
               imrst_pkg::PH2: m_sda_low_d = 1'b1;
               default: begin
                  m_scl_low_d = 1'b1;
                  m_sda_low_d = ~m_byte_q[7];
                  m_bit_d = '0;
                  m_st_d = imrst_pkg::M_BIT;
               end
            endcase
         end
         imrst_pkg::M_BIT: if (adv) begin
            m_ph_d = m_ph_q + 2'h1;
            case (m_ph_q)
               imrst_pkg::PH0: m_scl_low_d = 1'b0;
               imrst_pkg::PH1: begin
                  if (m_bit_q == imrst_pkg::ACK_BIT) begin
                     m_ack_d = ~line_s_q.sda;
                  end else begin
                     m_byte_d = {m_byte_q[6:0], line_s_q.sda};
                  end
                  if (m_rd_q && m_bit_q == imrst_pkg::LAST_DBIT) begin
                     rxd_d = {m_byte_q[6:0], line_s_q.sda};
                     rx_full_d = 1'b1;
                     cnt_d = cnt_q + 8'h01;
                  end
               end
               imrst_pkg::PH2: m_scl_low_d = 1'b1;
               default: begin
                  if (m_bit_q != imrst_pkg::ACK_BIT) begin
                     m_bit_d = m_bit_q + 4'h1;
                     if (m_bit_q == imrst_pkg::LAST_DBIT) begin
                        m_sda_low_d = m_rd_q & (cnt_q != len_q);
                     end else begin
                        m_sda_low_d = ~m_rd_q & ~m_byte_q[7];
                     end
                  end else if (!m_rd_q && !m_ack_q) begin
                     nack_d = 1'b1;
                     m_st_d = imrst_pkg::M_STOP;
                     m_sda_low_d = 1'b0;
                  end else if (!m_rd_q && m_step_q == imrst_pkg::ST_FIRST && mten_q) begin
                     m_step_d = imrst_pkg::ST_SECOND;
                     m_byte_d = tgt_q[7:0];
                     m_bit_d = '0;
                     m_sda_low_d = ~tgt_q[7];
                  end else if (!m_rd_q && m_step_q == imrst_pkg::ST_SECOND) begin
                     m_step_d = imrst_pkg::ST_FIRST_RD;
                     m_byte_d = {imrst_pkg::TEN_PREFIX, tgt_q[9:8], 1'b1};
                     m_st_d = imrst_pkg::M_START;
                  end else if (cnt_q == len_q) begin
                     m_st_d = imrst_pkg::M_STOP;
                     m_sda_low_d = 1'b0;
                  end else if (!rx_full_q) begin
                     m_step_d = imrst_pkg::ST_DATA;
                     m_rd_d = 1'b1;
                     m_bit_d = '0;
                     m_sda_low_d = 1'b0;
                  end else begin
                     m_ph_d = m_ph_q;
                  end
               end
            endcase
         end
         imrst_pkg::M_STOP: if (adv) begin
            m_ph_d = m_ph_q + 2'h1;
            case (m_ph_q)
               imrst_pkg::PH0: m_sda_low_d = 1'b1;
               imrst_pkg::PH1: m_scl_low_d = 1'b0;
               imrst_pkg::PH2: m_sda_low_d = 1'b0;
               default: begin
                  m_st_d = imrst_pkg::M_IDLE;
                  stop_d = 1'b1;
               end
            endcase
         end
         default: begin
            m_scl_low_d = 1'b0;
            m_sda_low_d = 1'b0;
         end
      endcase
      // Slave transmitter serving the channel when it reads as a master.
      if (!slv_en_q) begin
         s_st_d = imrst_pkg::S_IDLE;
         s_scl_low_d = 1'b0;
         s_sda_low_d = 1'b0;
      end else if (start_det) begin
         s_st_d = imrst_pkg::S_ADDR;
         s_cnt_d = '0;
         s_second_d = 1'b0;
         s_scl_low_d = 1'b0;
         s_sda_low_d = 1'b0;
      end else if (stop_det) begin
         if (s_addr_q) stop_d = 1'b1;
         s_st_d = imrst_pkg::S_IDLE;
         s_ten_ok_d = 1'b0;
         s_addr_d = 1'b0;
         s_scl_low_d = 1'b0;
         s_sda_low_d = 1'b0;
      end else begin
         case (s_st_q)
            imrst_pkg::S_ADDR: if (rise) begin
               s_shift_d = b;
               s_cnt_d = s_cnt_q + 3'h1;
               if (s_cnt_q == imrst_pkg::S_LAST) begin
                  s_rd_d = 1'b0;
                  if (s_second_q) begin
                     match = (b == own_q[7:0]);
                     s_ten_ok_d = match;
                     s_second_d = 1'b0;
                  end else if (oten_q) begin
                     match = (b[7:3] == imrst_pkg::TEN_PREFIX) && (b[2:1] == own_q[9:8])
                             && (!b[0] || s_ten_ok_q);
                     s_second_d = match & ~b[0];
                     s_rd_d = b[0];
                  end else begin
                     match = (b[7:1] == own_q[6:0]);
                     s_rd_d = b[0];
                  end
                  s_addr_d = s_addr_q | match;
                  s_st_d = match ? imrst_pkg::S_AACK : imrst_pkg::S_SKIP;
               end
            end
            imrst_pkg::S_AACK: if (fall) begin
               s_sda_low_d = ~s_sda_low_q;
               if (s_sda_low_q) begin
                  s_cnt_d = '0;
                  s_st_d = s_rd_q ? imrst_pkg::S_TWAIT
                         : (s_second_q ? imrst_pkg::S_ADDR : imrst_pkg::S_SKIP);
               end
            end
            imrst_pkg::S_TWAIT: begin
               s_scl_low_d = ~tx_full_q;
               if (tx_full_q) begin
                  s_shift_d = txd_q;
                  tx_full_d = acc & pwrite & (paddr == imrst_pkg::OFS_TXD);  // A fresh write wins.
                  s_sda_low_d = ~txd_q[7];
                  s_cnt_d = '0;
                  s_st_d = imrst_pkg::S_TX;
               end
            end
            imrst_pkg::S_TX: if (fall) begin
               if (s_cnt_q == imrst_pkg::S_LAST) begin
                  s_sda_low_d = 1'b0;
                  s_st_d = imrst_pkg::S_TACK;
               end else begin
                  s_cnt_d = s_cnt_q + 3'h1;
                  s_shift_d = {s_shift_q[6:0], 1'b0};
                  s_sda_low_d = ~s_shift_q[6];
               end
            end
            imrst_pkg::S_TACK: begin
               if (rise) begin
                  s_ack_d = ~line_s_q.sda;
                  if (line_s_q.sda) s_st_d = imrst_pkg::S_SKIP;
               end else if (fall && s_ack_q) begin
                  s_ack_d = 1'b0;
                  s_st_d = imrst_pkg::S_TWAIT;
               end
            end
            default: begin
               s_scl_low_d = 1'b0;
               s_sda_low_d = 1'b0;
            end
         endcase
      end
      scl_oe_n_d = ~(m_scl_low_d | s_scl_low_d);
      sda_oe_n_d = ~(m_sda_low_d | s_sda_low_d);
   end

   // ----------------------------------------------------------------
   // State registers
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         m_st_q <= imrst_pkg::M_IDLE;  m_step_q <= imrst_pkg::ST_FIRST;  m_ph_q <= '0;  m_bit_q <= '0;
         m_byte_q <= '0;  m_rd_q <= 1'b0;  m_scl_low_q <= 1'b0;  m_sda_low_q <= 1'b0;  m_ack_q <= 1'b0;
         s_st_q <= imrst_pkg::S_IDLE;  s_cnt_q <= '0;  s_shift_q <= '0;  s_scl_low_q <= 1'b0;
         s_sda_low_q <= 1'b0;  s_ten_ok_q <= 1'b0;  s_second_q <= 1'b0;  s_rd_q <= 1'b0;
         s_ack_q <= 1'b0;  s_addr_q <= 1'b0;  slv_en_q <= 1'b0;  mten_q <= 1'b0;  oten_q <= 1'b0;
         own_q <= '0;  tgt_q <= '0;  txd_q <= '0;  rxd_q <= '0;  tx_full_q <= 1'b0;  rx_full_q <= 1'b0;
         len_q <= '0;  cnt_q <= '0;  nack_q <= 1'b0;  stop_q <= 1'b0;  qcnt_q <= '0;
         prdata_q <= '0;  pready_q <= 1'b0;  pslverr_q <= 1'b0;  scl_oe_n_q <= 1'b1;  sda_oe_n_q <= 1'b1;
      end else begin
         m_st_q <= m_st_d;  m_step_q <= m_step_d;  m_ph_q <= m_ph_d;  m_bit_q <= m_bit_d;
         m_byte_q <= m_byte_d;  m_rd_q <= m_rd_d;  m_scl_low_q <= m_scl_low_d;  m_sda_low_q <= m_sda_low_d;
         m_ack_q <= m_ack_d;  s_st_q <= s_st_d;  s_cnt_q <= s_cnt_d;  s_shift_q <= s_shift_d;
         s_scl_low_q <= s_scl_low_d;  s_sda_low_q <= s_sda_low_d;  s_ten_ok_q <= s_ten_ok_d;
         s_second_q <= s_second_d;  s_rd_q <= s_rd_d;  s_ack_q <= s_ack_d;  s_addr_q <= s_addr_d;
         slv_en_q <= slv_en_d;  mten_q <= mten_d;  oten_q <= oten_d;  own_q <= own_d;  tgt_q <= tgt_d;
         txd_q <= txd_d;  rxd_q <= rxd_d;  tx_full_q <= tx_full_d;  rx_full_q <= rx_full_d;
         len_q <= len_d;  cnt_q <= cnt_d;  nack_q <= nack_d;  stop_q <= stop_d;  qcnt_q <= qcnt_d;
         prdata_q <= prdata_d;  pready_q <= pready_d;  pslverr_q <= pslverr_d;
         scl_oe_n_q <= scl_oe_n_d;  sda_oe_n_q <= sda_oe_n_d;
      end
   end

   // Outputs straight from flops, pin data outputs tied to 0; pins only ever pull low.
   assign prdata                = prdata_q;
   assign pready                = pready_q;
   assign pslverr               = pslverr_q;
   assign serial_clock_pin_o    = 1'b0;
   assign serial_clock_pin_oe_n = scl_oe_n_q;
   assign sda_o                 = 1'b0;
   assign sda_oe_n              = sda_oe_n_q;

endmodule : imrst_partner

//--- test/imrst_partner_properties.sv
// Checker of the APB timing and pin drive of imrst_partner.
// Sees only the top module's ports; bound to it at the foot of this file.
`timescale 1ns/1ps
module imrst_partner_chk (
   // Clock, reset and APB
   input wire logic        pclk, presetn, psel, penable, pwrite, pready, pslverr,
   input wire logic [31:0] prdata,
   // Pins
   input wire logic        serial_clock_pin_o, serial_clock_pin_oe_n, sda_o, sda_oe_n
);
   default clocking dc @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_acc; psel && !penable ##1 psel && penable; endsequence
   property p_wait; s_acc |=> pready; endproperty
   a_wait: assert property (p_wait) else $error("late pready");
   property p_early; psel && !penable |=> !pready; endproperty
   a_early: assert property (p_early) else $error("pready in setup");
   property p_pulse; pready |=> !pready; endproperty
   a_pulse: assert property (p_pulse) else $error("pready too long");
   property p_cause; pready |-> $past(psel && penable); endproperty
   a_cause: assert property (p_cause) else $error("pready uncaused");
   property p_err; pslverr |-> pready; endproperty
   a_err: assert property (p_err) else $error("stray pslverr");
   property p_rd0; pready && pslverr && !pwrite |-> prdata == 32'h0; endproperty
   a_rd0: assert property (p_rd0) else $error("refused read not zero");
   property p_rel; $rose(presetn) |-> sda_oe_n && serial_clock_pin_oe_n; endproperty
   a_rel: assert property (p_rel) else $error("lines held after reset");
   property p_odr; sda_o == 1'b0 && serial_clock_pin_o == 1'b0; endproperty
   a_odr: assert property (p_odr) else $error("pin drives high");
endmodule : imrst_partner_chk
bind imrst_partner imrst_partner_chk i_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .prdata(prdata), .serial_clock_pin_o(serial_clock_pin_o),
   .serial_clock_pin_oe_n(serial_clock_pin_oe_n), .sda_o(sda_o), .sda_oe_n(sda_oe_n));

//--- test/imrst_chan_model.sv
// Behavioural channel acting as a 7-bit slave transmitter on the two-wire bus.
// Assumes open-drain lines resolved by the bench with pull-ups.
`timescale 1ns/1ps
module imrst_chan_model (
   // Bus lines and setup
   input wire logic       scl, sda,
   input wire logic [6:0] own_addr,
   input wire logic [7:0] base, stall,
   // Pulls and observation
   output logic           scl_pull, sda_pull,
   output logic [7:0]     first_byte,
   output int             sent
);
   logic [7:0] sh;
   logic       ack;
   int         k, i;
   // Waits for a start, matches the address, then sends bytes while acked, stretching before each.
   initial begin
      scl_pull = 1'b0;
      sda_pull = 1'b0;
      first_byte = 8'h00;
      sent = 0;
      forever begin
         @(negedge sda iff scl === 1'b1);
         sent = 0;
         for (i = 0; i < 8; i++) begin
            @(posedge scl);
            sh = {sh[6:0], sda};
         end
         first_byte = sh;
         @(negedge scl);
         if (sh == {own_addr, 1'b1}) begin
            scl_pull = 1'b1;
            sda_pull = 1'b1;
            #(stall * 160 + 10);
            scl_pull = 1'b0;
            k = 0;
            do begin
               @(negedge scl);
               sh = base + k[7:0];
               sda_pull = ~sh[7];
               scl_pull = 1'b1;
               #(stall * 160 + 10);
               scl_pull = 1'b0;
               for (i = 7; i >= 0; i--) begin
                  sda_pull = ~sh[i];
                  @(negedge scl);
               end
               sda_pull = 1'b0;
               @(posedge scl);
               ack = ~sda;
               k++;
            end while (ack);
            sent = k;
         end
      end
   end
endmodule : imrst_chan_model

//--- test/tb.sv
// Bench: drives imrst_partner over APB against the channel model.
// Assumes the package, design and model are compiled first.
`timescale 1ns/1ps
module tb;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00, base = 8'h00, stall = 8'h00, first_byte;
   logic [31:0] pwdata = 32'h0, prdata, rd, st, r, seed = 32'h1A;
   logic        pready, pslverr, se, scl_oe_n, sda_oe_n, scl_pull, sda_pull;
   logic [9:0]  own = 10'h000;
   int          err_total = 0, num_checks = 0, got, t, sent, nw;
   wire         scl_w = scl_oe_n & ~scl_pull;
   wire         sda_w = sda_oe_n & ~sda_pull;
   always #20 pclk = ~pclk;
   imrst_partner i_imrst_partner (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .serial_clock_pin_i(scl_w), .serial_clock_pin_o(), .serial_clock_pin_oe_n(scl_oe_n),
      .sda_i(sda_w), .sda_o(), .sda_oe_n(sda_oe_n));
   imrst_chan_model i_imrst_chan_model (.scl(scl_w), .sda(sda_w), .own_addr(own[6:0]), .base(base),
      .stall(stall), .scl_pull(scl_pull), .sda_pull(sda_pull), .first_byte(first_byte), .sent(sent));
   function logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   task chk(input logic [31:0] g, e);
      num_checks++;
      if (g !== e) begin
         $display("FAIL %0t got %h want %h", $time, g, e);
         err_total++;
      end
   endtask : chk
   // One APB transfer; the request stands until pready is seen high.
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      se = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // Master read of n bytes, draining each byte, then flag checks; lb serves it from our own slave.
   task xfer(input logic [9:0] a, input int n, input logic ten, input logic nk, input logic lb);
      apb(1'b1, imrst_pkg::OFS_ADDR, (32'(a) << imrst_pkg::ADDR_TGT) | 32'(a));
      apb(1'b1, imrst_pkg::OFS_LEN, 32'(n));
      apb(1'b1, imrst_pkg::OFS_CTRL, {29'h0, ten, 1'b1, lb});
      got = 0;
      t = 0;
      nw = 0;
      do begin
         apb(1'b0, imrst_pkg::OFS_STAT, 32'h0);
         st = rd;
         t++;
         if (lb && st[1]) begin
            apb(1'b1, imrst_pkg::OFS_TXD, {24'h0, base + nw[7:0]});
            nw++;
         end
         if (st[2]) begin
            apb(1'b0, imrst_pkg::OFS_RXD, 32'h0);
            chk({24'h0, rd[7:0]}, {24'h0, base + got[7:0]});
            got++;
         end
      end while (st[0] || st[2] || t < 3);
      chk({24'h0, first_byte}, ten ? {24'h0, 5'h1E, a[9:8], 1'b0} : {24'h0, a[6:0], 1'b1});
      chk(32'(sent), (nk || lb) ? 32'h0 : 32'(n));
      chk(st & 32'hFF28, ((nk ? 0 : n) << 8) | 32'h20 | (nk ? 32'h8 : 32'h0));
      apb(1'b1, imrst_pkg::OFS_STAT, 32'h28);
      apb(1'b0, imrst_pkg::OFS_STAT, 32'h0);
      chk(rd & 32'h28, 32'h0);
   endtask : xfer
   task close_out();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : close_out
   // Main sequence: refused access, random reads, wrong address, own-slave loopback, ten-bit address.
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 8'h18, 32'h0);
      chk({31'h0, se}, 32'h1);
      chk(rd, 32'h0);
      for (int i = 0; i < 3; i++) begin
         r = rnd();
         own = r[9:0];
         base = r[17:10];
         stall = {2'h0, r[23:18]};
         xfer({3'h0, own[6:0]}, i == 0 ? 1 : 2 + int'(r[25:24]), 1'b0, 1'b0, 1'b0);
      end
      xfer({3'h0, own[6:0] ^ 7'h01}, 2, 1'b0, 1'b1, 1'b0);
      xfer({3'h0, own[6:0] ^ 7'h02}, 3, 1'b0, 1'b0, 1'b1);
      xfer(own, 1, 1'b1, 1'b1, 1'b0);
      close_out();
   end
   // Watchdog.
   initial begin
      #(40 * 95000);
      $display("FAIL %0t timeout", $time);
      err_total++;
      close_out();
   end
endmodule : tb
